// ### bose_exec.v
// Byte-op decoder and executor for set-all-ones and rotate-right-no-carry
// Function
// - Set-all-ones writes FFh to file register
// - Set-all-ones leaves the Z and N status flags alone
// - Recognise opcode top seven bits 0110100
// - Eight-bit file address, one-bit access select
// - Access bit clear: access bank; set: bank select
// - Extended set, a clear, f<=5Fh: indexed offset
// - Phases decode, read, process, write in order
// - Rotate with d set writes back to file
// - Rotate with d clear writes working register
// - Rotate right one, bit 0 into bit 7
// - Destination bit: clear working, set file
`timescale 1ns/100ps
`default_nettype none
`include "bose_consts.vh"

module bose_exec
(
   input wire sys_clk,
   input wire rstn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr
);

   localparam OP_NONE = 2'd0;
   localparam OP_SET_FILE_ALL_ONES = 2'd1;
   localparam OP_RRNC = 2'd2;

   reg [15:0] instr_q;
   reg [3:0] bank_select_register_q;
   reg [7:0] work_q;
   reg ext_en_q;
   reg [11:0] index_base_q;
   reg [11:0] eaddr_q;
   reg [2:0] phase_q;
   reg [1:0] op_q;
   reg [7:0] data_q;
   reg [7:0] result_q;
   reg flag_z_q;
   reg flag_n_q;
   reg bad_q;
   reg [7:0] file_q [0:`BOSE_FILE_WORDS-1];
   reg [31:0] rd_d;
   reg err_d;
   integer i;

   wire busy = (phase_q != `BOSE_PH_IDLE);
   wire acc_access = psel & penable;
   wire is_file = (paddr >= `BOSE_OFS_FILE) && (paddr < `BOSE_OFS_FILE + 8'h40);
   wire do_write = acc_access & pready & pwrite & ~pslverr;

   // Opcode classification
   function [1:0] decode_op;
      input [15:0] w;
      begin
         if (w[15:9] == `BOSE_SET_FILE_ALL_ONES_TOP)
            decode_op = OP_SET_FILE_ALL_ONES;
         else if (w[15:10] == `BOSE_RRNC_TOP)
            decode_op = OP_RRNC;
         else
            decode_op = OP_NONE;
      end
   endfunction

   // Effective data address from access bit, file field and modes
   function [11:0] eff_addr;
      input [15:0] w;
      input [3:0] bank;
      input ext;
      input [11:0] base;
      reg [7:0] f;
      begin
         f = w[7:0];
         if (w[`BOSE_BIT_A])
            eff_addr = {bank, f};
         else if (ext && (f <= `BOSE_LITOFS_MAX))
            eff_addr = base + {4'h0, f};
         else if (f < `BOSE_ACC_SPLIT)
            eff_addr = {`BOSE_ACC_LOW_BANK, f};
         else
            eff_addr = {`BOSE_ACC_HIGH_BANK, f};
      end
   endfunction

   // Read mux and error decision for the access phase
   always @*
   begin
      rd_d = 32'h0000_0000;
      err_d = 1'b0;
      if (is_file)
         rd_d = {24'h00_0000, file_q[paddr[5:2]]};
      else
      begin
         case (paddr)
            `BOSE_OFS_INSTR: rd_d = {16'h0000, instr_q};
            `BOSE_OFS_BANK: rd_d = {28'h000_0000, bank_select_register_q};
            `BOSE_OFS_WORK: rd_d = {24'h00_0000, work_q};
            `BOSE_OFS_CTRL: rd_d = {31'h0000_0000, ext_en_q};
            `BOSE_OFS_INDEX: rd_d = {20'h0_0000, index_base_q};
            `BOSE_OFS_STATUS: rd_d = {28'h000_0000, bad_q, flag_n_q, flag_z_q, busy};
            `BOSE_OFS_EADDR: rd_d = {20'h0_0000, eaddr_q};
            default: err_d = 1'b1;
         endcase
      end
      if (pwrite && busy)
         err_d = 1'b1;
      if (pwrite && (paddr == `BOSE_OFS_STATUS || paddr == `BOSE_OFS_EADDR))
         err_d = 1'b1;
   end

   // APB answer: one wait state, then ready with registered data
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else if (acc_access && !pready)
      begin
         pready <= 1'b1;
         pslverr <= err_d;
         prdata <= pwrite ? 32'h0000_0000 : rd_d;
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Software-set configuration and instruction launch
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         instr_q <= `BOSE_RST_INSTR;
         bank_select_register_q <= `BOSE_RST_BANK;
         ext_en_q <= 1'b0;
         index_base_q <= `BOSE_RST_INDEX;
      end
      else if (do_write)
      begin
         case (paddr)
            `BOSE_OFS_INSTR: instr_q <= pwdata[15:0];
            `BOSE_OFS_BANK: bank_select_register_q <= pwdata[3:0];
            `BOSE_OFS_CTRL: ext_en_q <= pwdata[`BOSE_CTRL_EXT];
            `BOSE_OFS_INDEX: index_base_q <= pwdata[11:0];
            default: ;
         endcase
      end
   end

   // Four-phase instruction cycle sequencer
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         phase_q <= `BOSE_PH_IDLE;
         op_q <= OP_NONE;
         eaddr_q <= 12'h000;
         data_q <= 8'h00;
         result_q <= 8'h00;
         bad_q <= 1'b0;
      end
      else
      begin
         case (phase_q)
            `BOSE_PH_IDLE:
               if (do_write && paddr == `BOSE_OFS_INSTR)
                  phase_q <= `BOSE_PH_DECODE;
            `BOSE_PH_DECODE:
            begin
               op_q <= decode_op(instr_q);
               eaddr_q <= eff_addr(instr_q, bank_select_register_q, ext_en_q, index_base_q);
               bad_q <= (decode_op(instr_q) == OP_NONE);
               phase_q <= `BOSE_PH_READ;
            end
            `BOSE_PH_READ:
            begin
               data_q <= file_q[eaddr_q[3:0]];
               phase_q <= `BOSE_PH_PROC;
            end
            `BOSE_PH_PROC:
            begin
               if (op_q == OP_SET_FILE_ALL_ONES)
                  result_q <= `BOSE_ALL_ONES;
               else
                  result_q <= {data_q[0], data_q[7:1]};
               phase_q <= `BOSE_PH_WRITE;
            end
            `BOSE_PH_WRITE:
               phase_q <= `BOSE_PH_IDLE;
            default:
               phase_q <= `BOSE_PH_IDLE;
         endcase
      end
   end

   // Write-back to file storage, working register and flags
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (i = 0; i < `BOSE_FILE_WORDS; i = i + 1)
            file_q[i] <= `BOSE_RST_FILE;
         work_q <= `BOSE_RST_WORK;
         flag_z_q <= 1'b0;
         flag_n_q <= 1'b0;
      end
      else if (do_write && is_file)
         file_q[paddr[5:2]] <= pwdata[7:0];
      else if (do_write && paddr == `BOSE_OFS_WORK)
         work_q <= pwdata[7:0];
      else if (phase_q == `BOSE_PH_WRITE)
      begin
         if (op_q == OP_SET_FILE_ALL_ONES)
            file_q[eaddr_q[3:0]] <= result_q;
         else if (op_q == OP_RRNC)
         begin
            if (instr_q[`BOSE_BIT_D])
               file_q[eaddr_q[3:0]] <= result_q;
            else
               work_q <= result_q;
            flag_z_q <= (result_q == 8'h00);
            flag_n_q <= result_q[7];
         end
      end
   end

endmodule
`default_nettype wire

// ### bose_consts.vh
// Constants for the byte-op set/rotate execute block
`ifndef BOSE_CONSTS_VH
`define BOSE_CONSTS_VH

// Register byte offsets
`define BOSE_OFS_INSTR 8'h00
`define BOSE_OFS_BANK 8'h04
`define BOSE_OFS_WORK 8'h08
`define BOSE_OFS_CTRL 8'h0C
`define BOSE_OFS_INDEX 8'h10
`define BOSE_OFS_STATUS 8'h14
`define BOSE_OFS_EADDR 8'h18
`define BOSE_OFS_FILE 8'h40
`define BOSE_FILE_WORDS 16

// Opcode layout
`define BOSE_SET_FILE_ALL_ONES_TOP 7'h34
`define BOSE_RRNC_TOP 6'h10
`define BOSE_ALL_ONES 8'hFF
`define BOSE_LITOFS_MAX 8'h5F
`define BOSE_ACC_SPLIT 8'h80
`define BOSE_ACC_LOW_BANK 4'h0
`define BOSE_ACC_HIGH_BANK 4'hF

// Field positions
`define BOSE_BIT_A 8
`define BOSE_BIT_D 9
`define BOSE_CTRL_EXT 0
`define BOSE_ST_BUSY 0
`define BOSE_ST_Z 1
`define BOSE_ST_N 2
`define BOSE_ST_BAD 3

// Reset values
`define BOSE_RST_INSTR 16'h0000
`define BOSE_RST_BANK 4'h0
`define BOSE_RST_WORK 8'h00
`define BOSE_RST_INDEX 12'h000
`define BOSE_RST_FILE 8'h00

// Phase codes of one instruction cycle, one clock each
`define BOSE_PH_IDLE 3'h0
`define BOSE_PH_DECODE 3'h1
`define BOSE_PH_READ 3'h2
`define BOSE_PH_PROC 3'h3
`define BOSE_PH_WRITE 3'h4

`endif

// ### bose_monitor.sv
// Bus timing and refusal checks for the byte-op execute block
`timescale 1ns/100ps
`default_nettype none
module bose_monitor
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic [2:0] busy_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Clocks left of a launched instruction
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         busy_q <= 3'h0;
      else if (pready && pwrite && !pslverr && paddr == 8'h00)
         busy_q <= 3'h4;
      else if (busy_q != 3'h0)
         busy_q <= busy_q - 3'h1;
   end
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready held too long");
   property p_wait; psel && $rose(penable) |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("answer late");
   property p_err; pslverr |-> pready && psel && penable; endproperty
   a_err: assert property (p_err) else $error("error outside access");
   property p_wzero; pready && pwrite |-> prdata == 32'h0; endproperty
   a_wzero: assert property (p_wzero) else $error("data on write");
   property p_ro; pready && pwrite && paddr inside {8'h14, 8'h18} |-> pslverr; endproperty
   a_ro: assert property (p_ro) else $error("read-only write taken");
   property p_unmap; pready && paddr inside {[8'h1C:8'h3C]} |-> pslverr && prdata == 0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped access taken");
   property p_busy; pready && pwrite && busy_q != 3'h0 |-> pslverr; endproperty
   a_busy: assert property (p_busy) else $error("write taken while busy");
   property p_work; pready && !pwrite && paddr == 8'h08 |-> prdata[31:8] == 0; endproperty
   a_work: assert property (p_work) else $error("working register too wide");
endmodule
bind bose_exec bose_monitor bose_mon_u (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));
`default_nettype wire

// ### tb.sv
// Self-checking bench for the byte-op execute block
`timescale 1ns/100ps
`default_nettype none
module tb;
   typedef struct packed {logic [15:0] op; logic [3:0] bank; logic ext; logic [11:0] base;
      logic [7:0] pre; logic [7:0] file; logic [7:0] work; logic [11:0] ea; logic [1:0] nz;} bose_row_t;
   logic sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er;
   int err_count = 0, total_checks = 0, cyc = 0, i;
   // Instruction, setup, preset, expected file, work, address, N/Z
   bose_row_t rows [8] = '{
      '{16'h4211, 4'h0, 1'b0, 12'h000, 8'hD7, 8'hEB, 8'h00, 12'h011, 2'h2},
      '{16'h4133, 4'h2, 1'b0, 12'h000, 8'hD7, 8'hD7, 8'hEB, 12'h233, 2'h2},
      '{16'h6925, 4'h3, 1'b0, 12'h000, 8'h12, 8'hFF, 8'h00, 12'h325, 2'h2},
      '{16'h68A7, 4'h3, 1'b0, 12'h000, 8'h12, 8'hFF, 8'h00, 12'hFA7, 2'h2},
      '{16'h685F, 4'h3, 1'b1, 12'h123, 8'h12, 8'hFF, 8'h00, 12'h182, 2'h2},
      '{16'h6860, 4'h3, 1'b1, 12'h123, 8'h12, 8'hFF, 8'h00, 12'h060, 2'h2},
      '{16'h4300, 4'h5, 1'b0, 12'h000, 8'h00, 8'h00, 8'h00, 12'h500, 2'h1},
      '{16'h6901, 4'h5, 1'b0, 12'h000, 8'h12, 8'hFF, 8'h00, 12'h501, 2'h1}};
   always #2.5 sys_clk = ~sys_clk;
   bose_exec dut_u (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   // Verdict and end of run
   task stop_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One bus transfer, held until ready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      // No own limit: only the run ceiling ends a hung wait
      while (pready !== 1'b1)
         @(posedge sys_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Launch and poll until idle
   task exec(input logic [15:0] op);
      apb(1'b1, 8'h00, {16'h0, op});
      rd = 32'h1;
      while (rd[0] !== 1'b0)
         apb(1'b0, 8'h14, 32'h0);
   endtask
   // Run ceiling
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         err_count++;
         stop_test();
      end
   end
   initial
   begin
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      apb(1'b0, 8'h14, 32'h0);
      chk("status", 32'h0, rd);
      for (i = 0; i < 8; i++)
      begin
         apb(1'b1, 8'h04, {28'h0, rows[i].bank});
         apb(1'b1, 8'h0C, {31'h0, rows[i].ext});
         apb(1'b1, 8'h10, {20'h0, rows[i].base});
         apb(1'b1, 8'h08, 32'h0);
         apb(1'b1, 8'h40 + {rows[i].ea[3:0], 2'b00}, {24'h0, rows[i].pre});
         exec(rows[i].op);
         chk("flags", {29'h0, rows[i].nz, 1'b0}, rd);
         apb(1'b0, 8'h18, 32'h0);
         chk("eaddr", {20'h0, rows[i].ea}, rd);
         apb(1'b0, 8'h40 + {rows[i].ea[3:0], 2'b00}, 32'h0);
         chk("file", {24'h0, rows[i].file}, rd);
         apb(1'b0, 8'h08, 32'h0);
         chk("work", {24'h0, rows[i].work}, rd);
      end
      // Refusals: unmapped, read-only, busy, bad opcode
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h1, {31'h0, er});
      apb(1'b1, 8'h14, 32'h0);
      chk("ro write", 32'h1, {31'h0, er});
      apb(1'b1, 8'h00, 32'h6901);
      apb(1'b1, 8'h08, 32'h55);
      chk("busy write", 32'h1, {31'h0, er});
      repeat (8) @(posedge sys_clk);
      apb(1'b0, 8'h08, 32'h0);
      chk("work kept", 32'h0, rd);
      exec(16'h0000);
      chk("bad op", 32'h1, {31'h0, rd[3]});
      // Reset in mid-run returns status, bank, work and one file word to their reset values
      apb(1'b1, 8'h08, 32'h5A);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      apb(1'b0, 8'h14, 32'h0);
      chk("status rst", 32'h0, rd);
      apb(1'b0, 8'h04, 32'h0);
      chk("bank rst", 32'h0, rd);
      apb(1'b0, 8'h08, 32'h0);
      chk("work rst", 32'h0, rd);
      apb(1'b0, 8'h44, 32'h0);
      chk("file rst", 32'h0, rd);
      stop_test();
   end
endmodule
`default_nettype wire
